// File: rtl/lbd_pkg.sv
package lbd_pkg;

    // ****************************************************************
    // widths and register map
    // ****************************************************************
    localparam int LBD_W = 8;
    localparam int LBD_AW = 3;
    localparam logic [LBD_AW-1:0] LBD_OFS_WREG = 3'h0;
    localparam logic [LBD_AW-1:0] LBD_OFS_FLAGS = 3'h1;
    localparam logic [LBD_AW-1:0] LBD_OFS_PDATA = 3'h2;
    localparam logic [LBD_AW-1:0] LBD_OFS_PDIR = 3'h3;
    localparam logic [LBD_AW-1:0] LBD_OFS_PIN = 3'h4;

    // ****************************************************************
    // flag positions and reset values
    // ****************************************************************
    localparam int LBD_FLG_Z = 0;
    localparam int LBD_FLG_C = 1;
    localparam int LBD_FLG_AUX = 2;
    localparam int LBD_FLG_OVF = 3;
    localparam int LBD_FLG_N = 4;
    localparam logic [LBD_W-1:0] LBD_RST_BYTE = 8'h00;
    localparam logic [LBD_FLG_N-1:0] LBD_RST_FLAGS = 4'h0;
    localparam logic [LBD_W-1:0] LBD_ONE = 8'h01;
    localparam logic [LBD_W-1:0] LBD_ZERO = 8'h00;

    // ****************************************************************
    // operations and carriers
    // ****************************************************************
    typedef enum logic [4:0] {
        LBD_NOP, LBD_AND_AI, LBD_AND_AM, LBD_AND_MA,
        LBD_OR_AI, LBD_OR_AM, LBD_OR_MA,
        LBD_XOR_AI, LBD_XOR_AM, LBD_XOR_MA, LBD_XOR_IOA,
        LBD_NOT_A, LBD_NOT_M, LBD_NEG_A, LBD_NEG_M,
        LBD_CLR_IO, LBD_SET_IO, LBD_CLR_M, LBD_SET_M, LBD_SWAPC
    } lbd_op_t;

    typedef enum logic [1:0] {
        LBD_DST_NONE, LBD_DST_WREG, LBD_DST_MEM, LBD_DST_IO
    } lbd_dst_t;

    typedef struct packed {
        lbd_op_t op;
        logic [LBD_W-1:0] imm;
        logic [LBD_W-1:0] mem_byte;
        logic [2:0] bit_sel;
    } lbd_req_t;

    typedef struct packed {
        logic we;
        logic [LBD_W-1:0] data;
    } lbd_mem_wr_t;

endpackage

// File: rtl/lbd_datapath.sv
`timescale 1ns/100ps
`default_nettype none

// Operation
// RULE1 - and: working register with immediate or memory byte into working register
// RULE2 - or: working register with immediate or memory byte into working register
// RULE3 - xor: working register with immediate or memory byte into working register
// RULE4 - memory-destination and/or/xor write memory byte, working register kept
// RULE5 - xor into port data register, all four flags untouched
// RULE6 - logic, not, neg update zero only; carry, aux, overflow kept
// RULE7 - not on working register inverts it in place
// RULE8 - not on memory inverts the byte and writes it back
// RULE9 - neg on working register: inverse plus one, modulo 256
// RULE10 - neg on memory: inverse plus one, written back
// RULE11 - bit clear / force high on port data touches only selected bit
// RULE12 - bit clear / force high on memory byte touches only selected bit
// RULE13 - single-bit clear and force high leave all four flags
// RULE14 - swap of port bit with carry changes only carry among flags
// RULE15 - output-direction bit: swap drives carry onto the port bit
// RULE16 - input-direction bit: swap loads sampled pin level into carry
// RULE17 - direction bit one means output, zero means input
// RULE18 - swap keeps zero, aux carry and overflow
// RULE19 - all data eight bits wide, bit index zero to seven
// RULE20 - zero flag set when written eight-bit result is zero
module lbd_datapath
    import lbd_pkg::*;
(
    input wire logic sys_clk, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic clk_en, // freezes all state when low
    input wire logic op_valid, // one-cycle operation request
    input wire lbd_req_t op_req, // operation, operands, bit index
    input wire logic [LBD_W-1:0] pin_level, // sampled port pin levels
    input wire logic [LBD_AW-1:0] bus_addr, // register address
    input wire logic [LBD_W-1:0] bus_wdata, // register write data
    input wire logic bus_wr, // write strobe
    input wire logic bus_rd, // read strobe
    output logic [LBD_W-1:0] bus_rdata, // read data, cycle after strobe
    output lbd_mem_wr_t mem_wr, // memory write-back pulse and byte
    output logic op_done, // pulse, operation retired
    output logic [LBD_W-1:0] working_register, // accumulator
    output logic [LBD_FLG_N-1:0] flags, // zero, carry, aux carry, overflow
    output logic [LBD_W-1:0] port_a_data, // port latch, drives pins
    output logic [LBD_W-1:0] port_dir // per-pin output enable
);

    // ****************************************************************
    // helpers
    // ****************************************************************

    // one-hot select of a bit, used by every bit operation
    function automatic logic [LBD_W-1:0] bit_mask(input logic [2:0] sel);
        bit_mask = LBD_ONE << sel; // [RULE19]
    endfunction

    function automatic logic is_zero(input logic [LBD_W-1:0] v);
        is_zero = (v == LBD_ZERO); // [RULE20]
    endfunction

    // ****************************************************************
    // operation decode
    // ****************************************************************
    logic [LBD_W-1:0] next_result;
    lbd_dst_t next_dst;
    logic next_upd_z;
    logic [LBD_W-1:0] sel_mask;
    logic sel_dir;
    logic sel_old;
    logic go;

    assign go = clk_en && op_valid;
    assign sel_mask = bit_mask(op_req.bit_sel);
    assign sel_dir = |(port_dir & sel_mask);
    assign sel_old = |(port_a_data & sel_mask);

    // result, destination and zero update for each operation
    always_comb
    begin
        next_result = working_register;
        next_dst = LBD_DST_NONE;
        next_upd_z = 1'b1; // [RULE6]
        case (op_req.op)
            LBD_AND_AI:
            begin
                next_result = working_register & op_req.imm; // [RULE1]
                next_dst = LBD_DST_WREG;
            end
            LBD_AND_AM:
            begin
                next_result = working_register & op_req.mem_byte; // [RULE1]
                next_dst = LBD_DST_WREG;
            end
            LBD_OR_AI:
            begin
                next_result = working_register | op_req.imm; // [RULE2]
                next_dst = LBD_DST_WREG;
            end
            LBD_OR_AM:
            begin
                next_result = working_register | op_req.mem_byte; // [RULE2]
                next_dst = LBD_DST_WREG;
            end
            LBD_XOR_AI:
            begin
                next_result = working_register ^ op_req.imm; // [RULE3]
                next_dst = LBD_DST_WREG;
            end
            LBD_XOR_AM:
            begin
                next_result = working_register ^ op_req.mem_byte; // [RULE3]
                next_dst = LBD_DST_WREG;
            end
            LBD_AND_MA:
            begin
                next_result = working_register & op_req.mem_byte; // [RULE4]
                next_dst = LBD_DST_MEM;
            end
            LBD_OR_MA:
            begin
                next_result = working_register | op_req.mem_byte; // [RULE4]
                next_dst = LBD_DST_MEM;
            end
            LBD_XOR_MA:
            begin
                next_result = working_register ^ op_req.mem_byte; // [RULE4]
                next_dst = LBD_DST_MEM;
            end
            LBD_XOR_IOA:
            begin
                next_result = working_register ^ port_a_data; // [RULE5]
                next_dst = LBD_DST_IO;
                next_upd_z = 1'b0; // [RULE5]
            end
            LBD_NOT_A:
            begin
                next_result = ~working_register; // [RULE7]
                next_dst = LBD_DST_WREG;
            end
            LBD_NOT_M:
            begin
                next_result = ~op_req.mem_byte; // [RULE8]
                next_dst = LBD_DST_MEM;
            end
            LBD_NEG_A:
            begin
                next_result = LBD_W'(~working_register + LBD_ONE); // [RULE9]
                next_dst = LBD_DST_WREG;
            end
            LBD_NEG_M:
            begin
                next_result = LBD_W'(~op_req.mem_byte + LBD_ONE); // [RULE10]
                next_dst = LBD_DST_MEM;
            end
            LBD_CLR_IO:
            begin
                next_result = port_a_data & ~sel_mask; // [RULE11]
                next_dst = LBD_DST_IO;
                next_upd_z = 1'b0; // [RULE13]
            end
            LBD_SET_IO:
            begin
                next_result = port_a_data | sel_mask; // [RULE11]
                next_dst = LBD_DST_IO;
                next_upd_z = 1'b0; // [RULE13]
            end
            LBD_CLR_M:
            begin
                next_result = op_req.mem_byte & ~sel_mask; // [RULE12]
                next_dst = LBD_DST_MEM;
                next_upd_z = 1'b0; // [RULE13]
            end
            LBD_SET_M:
            begin
                next_result = op_req.mem_byte | sel_mask; // [RULE12]
                next_dst = LBD_DST_MEM;
                next_upd_z = 1'b0; // [RULE13]
            end
            LBD_SWAPC:
            begin
                // carry lands in the latch whatever the direction
                if (flags[LBD_FLG_C])
                    next_result = port_a_data | sel_mask; // [RULE15]
                else
                    next_result = port_a_data & ~sel_mask; // [RULE15]
                next_dst = LBD_DST_IO;
                next_upd_z = 1'b0; // [RULE18]
            end
            default:
            begin
                next_upd_z = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // working register
    // ****************************************************************

    // an operation in the same cycle as a bus write wins
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            working_register <= LBD_RST_BYTE;
        else if (go && next_dst == LBD_DST_WREG)
            working_register <= next_result; // [RULE1] [RULE2] [RULE3]
        else if (clk_en && bus_wr && bus_addr == LBD_OFS_WREG)
            working_register <= bus_wdata;
    end

    // ****************************************************************
    // flags
    // ****************************************************************

    // operations: zero from result, carry only from the swap, aux and overflow never; a bus write loads all four
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            flags <= LBD_RST_FLAGS;
        else if (go && op_req.op == LBD_SWAPC)
        begin
            // input pin: sampled level; output pin: old latch bit
            if (sel_dir)
                flags[LBD_FLG_C] <= sel_old; // [RULE14] [RULE17]
            else
                flags[LBD_FLG_C] <= |(pin_level & sel_mask); // [RULE16] [RULE17]
        end
        else if (go && next_upd_z)
            flags[LBD_FLG_Z] <= is_zero(next_result); // [RULE6] [RULE20]
        else if (clk_en && bus_wr && bus_addr == LBD_OFS_FLAGS)
            flags <= bus_wdata[LBD_FLG_N-1:0];
    end

    // ****************************************************************
    // port latch and direction
    // ****************************************************************

    // latch drives the pins only where the direction bit is one
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            port_a_data <= LBD_RST_BYTE;
        else if (go && next_dst == LBD_DST_IO)
            port_a_data <= next_result; // [RULE5] [RULE11] [RULE15]
        else if (clk_en && bus_wr && bus_addr == LBD_OFS_PDATA)
            port_a_data <= bus_wdata;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            port_dir <= LBD_RST_BYTE;
        else if (clk_en && bus_wr && bus_addr == LBD_OFS_PDIR)
            port_dir <= bus_wdata; // [RULE17]
    end

    // ****************************************************************
    // memory write-back and completion
    // ****************************************************************

    // one-cycle write pulse; the byte holds until the next write
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_wr.we <= 1'b0;
            mem_wr.data <= LBD_RST_BYTE;
        end
        else if (clk_en)
        begin
            mem_wr.we <= go && next_dst == LBD_DST_MEM; // [RULE4] [RULE8]
            if (go && next_dst == LBD_DST_MEM)
                mem_wr.data <= next_result; // [RULE10] [RULE12]
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            op_done <= 1'b0;
        else if (clk_en)
            op_done <= go;
    end

    // ****************************************************************
    // register read port
    // ****************************************************************

    // unmapped addresses read as zero; data only in the next cycle
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            bus_rdata <= LBD_RST_BYTE;
        else if (clk_en)
        begin
            bus_rdata <= LBD_ZERO;
            if (bus_rd)
            begin
                case (bus_addr)
                    LBD_OFS_WREG: bus_rdata <= working_register;
                    LBD_OFS_FLAGS: bus_rdata <= LBD_W'(flags);
                    LBD_OFS_PDATA: bus_rdata <= port_a_data;
                    LBD_OFS_PDIR: bus_rdata <= port_dir;
                    LBD_OFS_PIN: bus_rdata <= pin_level;
                    default: bus_rdata <= LBD_ZERO;
                endcase
            end
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_op(lbd_op_t o);
        go && op_req.op == o;
    endsequence

    property p_and_imm;
        s_op(LBD_AND_AI) |=> working_register == ($past(working_register) & $past(op_req.imm));
    endproperty
    a_and_imm: assert property (p_and_imm) else $error("and immediate wrong"); // [RULE1]

    property p_or_mem;
        s_op(LBD_OR_AM) |=> working_register == ($past(working_register) | $past(op_req.mem_byte));
    endproperty
    a_or_mem: assert property (p_or_mem) else $error("or memory wrong"); // [RULE2]

    property p_xor_imm;
        s_op(LBD_XOR_AI) |=> working_register == ($past(working_register) ^ $past(op_req.imm));
    endproperty
    a_xor_imm: assert property (p_xor_imm) else $error("xor immediate wrong"); // [RULE3]

    property p_mem_dst;
        (s_op(LBD_AND_MA) or s_op(LBD_OR_MA) or s_op(LBD_XOR_MA))
            |=> mem_wr.we && $stable(working_register)
            ##1 mem_wr.we == (!$past(clk_en) || $past(go && next_dst == LBD_DST_MEM));
    endproperty
    a_mem_dst: assert property (p_mem_dst) else $error("memory destination wrong"); // [RULE4]

    property p_xor_io;
        s_op(LBD_XOR_IOA) |=> $stable(flags)
            && port_a_data == ($past(working_register) ^ $past(port_a_data));
    endproperty
    a_xor_io: assert property (p_xor_io) else $error("xor io wrong"); // [RULE5]

    property p_neg_a;
        s_op(LBD_NEG_A) |=> working_register == LBD_W'(LBD_ZERO - $past(working_register))
            && flags[LBD_FLG_Z] == (working_register == LBD_ZERO)
            && flags[LBD_FLG_N-1:LBD_FLG_C] == $past(flags[LBD_FLG_N-1:LBD_FLG_C]);
    endproperty
    a_neg_a: assert property (p_neg_a) else $error("negate wrong"); // [RULE9]

    property p_not_m;
        s_op(LBD_NOT_M) |=> mem_wr.we && mem_wr.data == ~$past(op_req.mem_byte);
    endproperty
    a_not_m: assert property (p_not_m) else $error("complement memory wrong"); // [RULE8]

    property p_bit_io;
        (s_op(LBD_CLR_IO) or s_op(LBD_SET_IO)) |=> $stable(flags)
            && ((port_a_data ^ $past(port_a_data)) & ~$past(sel_mask)) == LBD_ZERO
            && port_a_data[$past(op_req.bit_sel)] == ($past(op_req.op) == LBD_SET_IO);
    endproperty
    a_bit_io: assert property (p_bit_io) else $error("bit op io wrong"); // [RULE11]

    property p_swap_out;
        s_op(LBD_SWAPC) ##0 sel_dir |=> port_a_data[$past(op_req.bit_sel)]
            == $past(flags[LBD_FLG_C]) && flags[LBD_FLG_C] == $past(sel_old);
    endproperty
    a_swap_out: assert property (p_swap_out) else $error("swap output wrong"); // [RULE15]

    property p_swap_in;
        s_op(LBD_SWAPC) ##0 !sel_dir |=> flags[LBD_FLG_C] == $past(pin_level[op_req.bit_sel])
            && flags[LBD_FLG_Z] == $past(flags[LBD_FLG_Z])
            && flags[LBD_FLG_OVF:LBD_FLG_AUX] == $past(flags[LBD_FLG_OVF:LBD_FLG_AUX]);
    endproperty
    a_swap_in: assert property (p_swap_in) else $error("swap input wrong"); // [RULE16]

endmodule

`default_nettype wire

// File: bench/lbd_far_model.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// far side: data memory bytes and port pin levels
// ****************************************************************
module lbd_far_model
    import lbd_pkg::*;
(
    input wire logic sys_clk, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic [3:0] mem_addr, // byte the current op works on
    input wire lbd_mem_wr_t mem_wr, // write-back from the datapath
    output logic [LBD_W-1:0] mem_byte, // addressed byte, combinational
    output logic [LBD_W-1:0] pin_level // pin levels, new every cycle
);
    logic [LBD_W-1:0] mem [16];

    // memory: write-back lands on the byte still addressed by the op
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 16; i++)
                mem[i] <= LBD_W'(i * 37 + 5);
        end
        else if (mem_wr.we)
            mem[mem_addr] <= mem_wr.data;
    end

    assign mem_byte = mem[mem_addr];

    // pins wander every cycle so a stale sample never passes
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            pin_level <= 8'hA5;
        else
            pin_level <= {pin_level[6:0], pin_level[7] ^ pin_level[5] ^ pin_level[3]};
    end
endmodule
`default_nettype wire

// File: bench/tb_lbd_datapath.sv
`timescale 1ns/100ps
`default_nettype none

module tb_lbd_datapath;
    import lbd_pkg::*;

    // ****************************************************************
    // stimulus signals and reference state
    // ****************************************************************
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic op_valid = 1'b0;
    lbd_op_t cur_op = LBD_NOP;
    logic [7:0] cur_imm = 8'h00;
    logic [2:0] cur_bit = 3'h0;
    logic [3:0] cur_addr = 4'h0;
    logic [2:0] bus_addr = 3'h0;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] bus_rdata, mem_byte, pin_level, working_register, port_a_data, port_dir;
    logic [3:0] flags;
    logic op_done;
    lbd_mem_wr_t mem_wr;
    lbd_req_t op_req;
    int miscompares = 0;
    int samples_checked = 0;
    int seed = 4845;
    int w, port, dir, fz, fc, fa, fo;
    int mem [16];

    assign op_req = '{op: cur_op, imm: cur_imm, mem_byte: mem_byte, bit_sel: cur_bit};

    always #5 sys_clk = ~sys_clk;

    lbd_datapath uut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .op_valid(op_valid), .op_req(op_req), .pin_level(pin_level),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .mem_wr(mem_wr), .op_done(op_done),
        .working_register(working_register), .flags(flags),
        .port_a_data(port_a_data), .port_dir(port_dir));

    lbd_far_model far (.sys_clk(sys_clk), .rst_n(rst_n), .mem_addr(cur_addr),
        .mem_wr(mem_wr), .mem_byte(mem_byte), .pin_level(pin_level));

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic bus_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic bus_read(input logic [2:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1;
        check("bus_rdata", bus_rdata, exp);
        @(posedge sys_clk);
        #1;
        check("bus_rdata idle", bus_rdata, 8'h00);
    endtask

    // one op, then the model's view compared at every output but bus_rdata and port_dir
    task automatic do_op(input int opn, input int imm, input int b, input int a);
        int mb, pin, r, old_c;
        lbd_op_t op;
        op = lbd_op_t'(opn);
        @(posedge sys_clk);
        op_valid <= 1'b1;
        cur_op <= op;
        cur_imm <= 8'(imm);
        cur_bit <= 3'(b);
        cur_addr <= 4'(a);
        #1;
        mb = mem[a];
        pin = pin_level;
        check("mem_byte", mem_byte, 8'(mb));
        r = -1;
        case (op)
            LBD_AND_AI: w = w & imm;
            LBD_AND_AM: w = w & mb;
            LBD_AND_MA: r = w & mb;
            LBD_OR_AI: w = w | imm;
            LBD_OR_AM: w = w | mb;
            LBD_OR_MA: r = w | mb;
            LBD_XOR_AI: w = w ^ imm;
            LBD_XOR_AM: w = w ^ mb;
            LBD_XOR_MA: r = w ^ mb;
            LBD_XOR_IOA: port = port ^ w;
            LBD_NOT_A: w = ~w & 255;
            LBD_NOT_M: r = ~mb & 255;
            LBD_NEG_A: w = (256 - w) & 255;
            LBD_NEG_M: r = (256 - mb) & 255;
            LBD_CLR_IO: port = port & ~(1 << b);
            LBD_SET_IO: port = port | (1 << b);
            LBD_CLR_M: r = mb & ~(1 << b) & 255;
            LBD_SET_M: r = mb | (1 << b);
            LBD_SWAPC:
            begin
                old_c = fc;
                fc = ((dir >> b) & 1) ? (port >> b) & 1 : (pin >> b) & 1;
                port = (port & ~(1 << b)) | (old_c << b);
            end
            default: ;
        endcase
        // zero flag only for logic, not and neg, never for port xor
        if (opn >= 1 && opn <= 14 && opn != 10)
            fz = (r >= 0) ? (r == 0) : (w == 0);
        if (r >= 0)
            mem[a] = r;
        @(posedge sys_clk);
        op_valid <= 1'b0;
        #1;
        check("op_done", 8'(op_done), 8'h01);
        check("mem_we", 8'(mem_wr.we), 8'(r >= 0));
        if (r >= 0)
            check("mem_data", mem_wr.data, 8'(r));
        check("working_register", working_register, 8'(w));
        check("flags", 8'(flags), 8'(fo * 8 + fa * 4 + fc * 2 + fz));
        check("port_a_data", port_a_data, 8'(port));
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        w = 0;
        port = 0;
        dir = 0;
        fz = 0;
        fc = 0;
        fa = 0;
        fo = 0;
        for (int i = 0; i < 16; i++)
            mem[i] = (i * 37 + 5) & 255;
        #1;
        check("reset wreg", working_register, 8'h00);
        check("reset flags", 8'(flags), 8'h00);
        // aux carry and overflow set so that keeping them is visible
        bus_write(LBD_OFS_PDIR, 8'h0F);
        bus_write(LBD_OFS_FLAGS, 8'h0C);
        dir = 15;
        fa = 1;
        fo = 1;
        bus_read(LBD_OFS_FLAGS, 8'h0C);
        bus_read(LBD_OFS_PDIR, 8'h0F);
        bus_read(3'h5, 8'h00);
        // plain register writes, and a refused write to the pin level
        bus_write(LBD_OFS_WREG, 8'h5A);
        bus_write(LBD_OFS_PDATA, 8'hC3);
        bus_write(LBD_OFS_PIN, 8'hFF);
        bus_read(LBD_OFS_WREG, 8'h5A);
        bus_read(LBD_OFS_PDATA, 8'hC3);
        w = 'h5A;
        port = 'hC3;
        $display("test bus access done");
        // every code once, bit index walks across both directions
        for (int i = 0; i < 20; i++)
            do_op(i, (i * 29 + 3) & 255, i % 8, i % 16);
        do_op(1, 0, 7, 0);
        do_op(13, 0, 0, 0);
        // undefined code: only the completion pulse
        do_op(25, 8'hFF, 3, 5);
        $display("test code sweep done");
        // frozen cycle: a request with the enable low must not retire
        @(posedge sys_clk);
        clk_en <= 1'b0;
        op_valid <= 1'b1;
        cur_op <= LBD_NOT_A;
        @(posedge sys_clk);
        clk_en <= 1'b1;
        op_valid <= 1'b0;
        #1;
        check("frozen op_done", 8'(op_done), 8'h00);
        check("frozen wreg", working_register, 8'(w));
        $display("test clock enable done");
        for (int n = 0; n < 300; n++)
        begin
            if (n % 50 == 0)
            begin
                dir = $random(seed) & 255;
                bus_write(LBD_OFS_PDIR, 8'(dir));
            end
            do_op($unsigned($random(seed)) % 20, $random(seed) & 255,
                $unsigned($random(seed)) % 8, $unsigned($random(seed)) % 16);
        end
        $display("test random ops done");
        complete_run();
    end

    // watchdog well past the roughly 700 cycles the tests need
    initial
    begin
        #300000;
        miscompares++;
        complete_run();
    end
endmodule
`default_nettype wire
